// *** rtcs_pkg.sv ***
`default_nettype none
package rtcs_pkg;
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  OFS_CON1      = 8'h00;
    localparam logic [7:0]  OFS_CON2      = 8'h10;
    localparam logic [7:0]  OFS_STAT      = 8'h30;
    localparam logic [7:0]  OFS_TIME      = 8'h40;
    localparam logic [7:0]  OFS_ALM       = 8'h60;
    localparam logic [1:0]  OP_WR         = 2'h0;
    localparam logic [1:0]  OP_CLR        = 2'h1;
    localparam logic [1:0]  OP_SET        = 2'h2;
    localparam logic [1:0]  OP_INV        = 2'h3;
    localparam int          C1_ALARM_ENABLE_BIT     = 31;
    localparam int          C1_CHIME      = 30;
    localparam int          C1_AMASK_LSB  = 24;
    localparam int          C1_RPT_LSB    = 16;
    localparam int          C1_ON         = 15;
    localparam int          C1_LOCK       = 11;
    localparam int          C1_OE         = 7;
    localparam int          C1_OSEL_LSB   = 4;
    localparam int          C2_DIV_LSB    = 16;
    localparam int          C2_FDIV_LSB   = 11;
    localparam int          C2_CSEL_LSB   = 0;
    localparam int          ST_EVT        = 5;
    localparam int          ST_SYNC       = 2;
    localparam int          ST_ASYNC      = 1;
    localparam int          ST_HALF       = 0;
    localparam int          T_HRT_LSB     = 28;
    localparam int          T_HRO_LSB     = 24;
    localparam int          T_MINT_LSB    = 20;
    localparam int          T_MINO_LSB    = 16;
    localparam int          T_SECT_LSB    = 12;
    localparam int          T_SECO_LSB    = 8;
    localparam logic [31:0] CON1_MASK     = 32'hcfff88f0;
    localparam logic [31:0] CON2_MASK     = 32'hfffff803;
    localparam logic [31:0] TIME_MASK     = 32'h7f7fff00;
    localparam logic [31:0] RESET_REG     = 32'h00000000;
    localparam logic [2:0]  OSEL_ALARM    = 3'h0;
    localparam logic [2:0]  OSEL_SECONDS  = 3'h1;
    localparam logic [2:0]  OSEL_SRCCLK   = 3'h2;
    localparam logic [1:0]  CSEL_SECONDARY_CRYSTAL_OSC     = 2'h0;
    localparam logic [1:0]  CSEL_LOW_POWER_RC_OSC     = 2'h1;
    localparam logic [1:0]  CSEL_PIN      = 2'h2;
    localparam logic [1:0]  CSEL_PERIPH   = 2'h3;
    localparam logic [15:0] SYNC_MARGIN   = 16'h0003;
endpackage
`default_nettype wire

// *** rtcs_top.sv ***
// What this block does
// - Lock bit set blocks software writes to timekeeping registers.
// - Output enable drives selected signal on pin; clear disables pin.
// - Select 010 source clock, 001 seconds clock, 000 alarm event.
// - Repeat counter decrements by one on each alarm event.
// - Repeat counter holds at 00 unless chime set, then wraps to FF.
// - Upper 16 bits of control two set divider reload period.
// - Trim N adds N source cycles per 16 seconds.
// - Trim zero gives no adjustment; integer divide alone.
// - Two-bit select picks peripheral, pin, RC or crystal source.
// - Alarm event flag is read-only, hardware set and cleared.
// - Time-sync flag high while time registers may change.
// - Alarm-sync flag high while alarm enable or count may change.
// - Half-second flag reads one in second half of each second.
// - Hours BCD: tens at 30-28, units at 27-24.
// - Minutes BCD: tens at 22-20, units at 19-16.
// - Seconds BCD: tens at 15-12, units at 11-8.
// - Alarm time register uses the same field layout.
// - Unimplemented bits ignore writes and read zero.
// - Enable bit set counts from selected source; clear stops counting.
// - Eight-bit repeat count gives 0 to 255 further repeats.
`timescale 1ns/1ps
`default_nettype none
module rtcs_top
(
    input  wire logic                       I_CLK,
    input  wire logic                       I_RST_N,
    input  wire logic                       I_CE,
    input  wire logic [rtcs_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
    input  wire logic                       I_AVS_READ,
    input  wire logic                       I_AVS_WRITE,
    input  wire logic [31:0]                I_AVS_WRITEDATA,
    input  wire logic [3:0]                 I_AVS_BYTEENABLE,
    output logic      [31:0]                O_AVS_READDATA,
    output logic                            O_AVS_WAITREQUEST,
    input  wire logic                       I_UNLOCKED,
    input  wire logic                       I_SECONDARY_CRYSTAL_OSC,
    input  wire logic                       I_LOW_POWER_RC_OSC,
    input  wire logic                       I_DEDICATED_CLOCK_PIN,
    output logic                            O_CC_PIN,
    output logic                            O_CC_PIN_OE,
    output logic                            O_ALARM_EVENT,
    output logic                            O_ENABLED
);
    import rtcs_pkg::*;

    typedef struct packed {
        logic [31:0] con1;
        logic [31:0] con2;
        logic [31:0] tim;
        logic [31:0] alm;
        logic [15:0] cnt;
        logic [4:0]  phase;
        logic        half;
        logic        evt;
        logic [2:0]  sy1;
        logic [2:0]  sy2;
        logic        lvl_prev;
        logic [3:0]  stat;
        logic        ack;
        logic [31:0] rdata;
        logic        pin;
        logic        pin_oe;
    } rtcs_state_t;

    rtcs_state_t s_r;
    rtcs_state_t s_nxt;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] apply_wr(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be,
                                             input logic [1:0]  op,
                                             input logic [31:0] mask);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask & wd;
        case (op)
            OP_WR:   apply_wr = (old & ~({{8{be[3]}}, {8{be[2]}}, {8{be[1]}},
                                {8{be[0]}}} & mask)) | m;
            OP_CLR:  apply_wr = old & ~m;
            OP_SET:  apply_wr = old | m;
            default: apply_wr = old ^ m;
        endcase
    endfunction

    function automatic logic [3:0] bcd_step(input logic [3:0] d,
                                            input logic [3:0] top,
                                            output logic      carry);
        carry = (d >= top);
        bcd_step = carry ? 4'h0 : 4'(d + 4'h1);
    endfunction

    // Wraps at 23:59:59; a carry ripples only while lower digits roll over
    function automatic logic [31:0] time_inc(input logic [31:0] t);
        logic [3:0]  so;
        logic [3:0]  st;
        logic [3:0]  mo;
        logic [3:0]  mt;
        logic [3:0]  ho;
        logic [3:0]  ht;
        logic        c;
        logic [31:0] r;
        so = t[T_SECO_LSB +: 4];
        st = t[T_SECT_LSB +: 4];
        mo = t[T_MINO_LSB +: 4];
        mt = {1'b0, t[T_MINT_LSB +: 3]};
        ho = t[T_HRO_LSB +: 4];
        ht = {1'b0, t[T_HRT_LSB +: 3]};
        so = bcd_step(so, 4'h9, c);
        if (c)
            st = bcd_step(st, 4'h5, c);
        if (c)
            mo = bcd_step(mo, 4'h9, c);
        if (c)
            mt = bcd_step(mt, 4'h5, c);
        if (c)
        begin
            if (ht == 4'h2 && ho == 4'h3)
            begin
                ho = 4'h0;
                ht = 4'h0;
            end
            else
            begin
                ho = bcd_step(ho, 4'h9, c);
                if (c)
                    ht = 4'(ht + 4'h1);
            end
        end
        r = 32'h0;
        r[T_HRT_LSB +: 3]  = ht[2:0];
        r[T_HRO_LSB +: 4]  = ho;
        r[T_MINT_LSB +: 3] = mt[2:0];
        r[T_MINO_LSB +: 4] = mo;
        r[T_SECT_LSB +: 4] = st;
        r[T_SECO_LSB +: 4] = so;
        time_inc = r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic        req;
    logic        acc;
    logic        wr;
    logic [7:0]  ofs;
    logic [1:0]  op;
    logic [1:0]  csel;
    logic        src_lvl;
    logic        tick;
    logic        uf;
    logic        sec_adv;
    logic [31:0] tim_new;
    logic        alarm_hit;
    logic        sync_f;
    logic        async_f;
    logic [15:0] reload;
    logic [31:0] c1_w;
    logic [31:0] rd;

    assign req = I_AVS_READ | I_AVS_WRITE;
    assign acc = req & s_r.ack;
    assign wr  = I_AVS_WRITE & acc;
    assign ofs = {I_AVS_ADDRESS[7:4], 4'h0};
    assign op  = I_AVS_ADDRESS[3:2];
    assign csel = s_r.con2[C2_CSEL_LSB +: 2];

    assign src_lvl = (csel == CSEL_PERIPH) ? 1'b0 : s_r.sy2[csel];
    assign tick = s_r.con1[C1_ON] &
                  ((csel == CSEL_PERIPH) | (src_lvl & ~s_r.lvl_prev));
    assign uf = tick & (s_r.cnt == 16'h0000);
    // Seconds advance on every second underflow
    assign sec_adv = uf & s_r.half;
    assign tim_new = time_inc(s_r.tim);
    assign alarm_hit = sec_adv & s_r.con1[C1_ALARM_ENABLE_BIT] & (tim_new == s_r.alm);
    // Extra cycle in N of every 32 half-second periods
    // Integer reload from upper half of control two
    // Trim zero adds nothing to the reload
    assign reload = 16'(s_r.con2[C2_DIV_LSB +: 16] +
                        {15'h0, s_r.phase < s_r.con2[C2_FDIV_LSB +: 5]});
    // Time may roll over within the next few source ticks
    assign sync_f = s_r.con1[C1_ON] & s_r.half & (s_r.cnt <= SYNC_MARGIN);
    // Alarm controls only change on a second boundary
    assign async_f = sync_f & s_r.con1[C1_ALARM_ENABLE_BIT];

    always_comb
    begin
        c1_w = apply_wr(s_r.con1, I_AVS_WRITEDATA, I_AVS_BYTEENABLE, op, CON1_MASK);
        if (s_r.con1[C1_LOCK] && !c1_w[C1_LOCK] && !I_UNLOCKED)
            c1_w[C1_LOCK] = 1'b1;
    end

    // Unmapped and reserved bits read zero
    always_comb
    begin
        case (ofs)
            OFS_CON1: rd = s_r.con1 & CON1_MASK;
            OFS_CON2: rd = s_r.con2 & CON2_MASK;
            // Half flag read as the status low bit
            OFS_STAT: rd = {26'h0, s_r.stat[3], 2'h0, s_r.stat[2:0]};
            OFS_TIME: rd = s_r.tim & TIME_MASK;
            OFS_ALM:  rd = s_r.alm & TIME_MASK;
            default:  rd = 32'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.ack = req & ~s_r.ack;
        if (req && !s_r.ack)
            s_nxt.rdata = rd;
        s_nxt.sy1 = {I_DEDICATED_CLOCK_PIN, I_LOW_POWER_RC_OSC, I_SECONDARY_CRYSTAL_OSC};
        s_nxt.sy2 = s_r.sy1;
        s_nxt.lvl_prev = src_lvl;
        if (tick)
            s_nxt.cnt = uf ? reload : 16'(s_r.cnt - 16'h1);
        if (uf)
        begin
            s_nxt.half = ~s_r.half;
            s_nxt.phase = 5'(s_r.phase + 5'h1);
        end
        if (sec_adv)
            s_nxt.tim = tim_new;
        // Cleared by the next underflow, a new hit wins
        s_nxt.evt = (s_r.evt & ~uf) | alarm_hit;
        // Full eight-bit count, up to 255 repeats
        if (alarm_hit)
        begin
            if (s_r.con1[C1_RPT_LSB +: 8] == 8'h00 && !s_r.con1[C1_CHIME])
                s_nxt.con1[C1_ALARM_ENABLE_BIT] = 1'b0;
            else
                s_nxt.con1[C1_RPT_LSB +: 8] = 8'(s_r.con1[C1_RPT_LSB +: 8] - 8'h1);
        end
        // Status captured into the bus-side copy
        s_nxt.stat = {s_r.evt, sync_f, async_f, s_r.half};
        if (wr)
        begin
            case (ofs)
                OFS_CON1: s_nxt.con1 = c1_w;
                OFS_CON2:
                    if (!s_r.con1[C1_LOCK])
                        s_nxt.con2 = apply_wr(s_r.con2, I_AVS_WRITEDATA,
                                              I_AVS_BYTEENABLE, op, CON2_MASK);
                OFS_TIME:
                    if (!s_r.con1[C1_LOCK])
                        s_nxt.tim = apply_wr(s_r.tim, I_AVS_WRITEDATA,
                                             I_AVS_BYTEENABLE, op, TIME_MASK);
                OFS_ALM:  s_nxt.alm = apply_wr(s_r.alm, I_AVS_WRITEDATA,
                                               I_AVS_BYTEENABLE, op, TIME_MASK);
                default:  s_nxt.alm = s_nxt.alm;
            endcase
        end
        s_nxt.pin_oe = s_r.con1[C1_OE];
        // Pin source mux; reserved codes drive low
        case (s_r.con1[C1_OSEL_LSB +: 3])
            OSEL_ALARM:   s_nxt.pin = s_r.evt;
            OSEL_SECONDS: s_nxt.pin = s_r.half;
            OSEL_SRCCLK:  s_nxt.pin = (csel == CSEL_PERIPH) ? tick : src_lvl;
            default:      s_nxt.pin = 1'b0;
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            s_r <= '0;
            s_r.con1 <= RESET_REG;
            s_r.con2 <= RESET_REG;
        end
        else if (I_CE)
            s_r <= s_nxt;
    end

    // Waitrequest is combinational so a request is answered one cycle later
    // A frozen cycle must not answer a write that it cannot take
    assign O_AVS_WAITREQUEST = req & ~(s_r.ack & I_CE);
    assign O_AVS_READDATA    = s_r.rdata;
    assign O_CC_PIN          = s_r.pin;
    assign O_CC_PIN_OE       = s_r.pin_oe;
    assign O_ALARM_EVENT     = s_r.evt;
    assign O_ENABLED         = s_r.con1[C1_ON];

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_N);

    property p_lock_con2;
        I_CE && wr && ofs == OFS_CON2 && s_r.con1[C1_LOCK] |=> $stable(s_r.con2);
    endproperty
    a_lock_con2: assert property (p_lock_con2) else $error("locked write changed");

    property p_unlock_needed;
        I_CE && s_r.con1[C1_LOCK] && !I_UNLOCKED |=> s_r.con1[C1_LOCK];
    endproperty
    a_unlock_needed: assert property (p_unlock_needed) else $error("lock cleared");

    property p_pin_off;
        I_CE && !s_r.con1[C1_OE] |=> !O_CC_PIN_OE;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("pin driven while off");

    property p_pin_sec;
        I_CE && s_r.con1[C1_OSEL_LSB +: 3] == OSEL_SECONDS |=> O_CC_PIN == $past(s_r.half);
    endproperty
    a_pin_sec: assert property (p_pin_sec) else $error("seconds clock not on pin");

    property p_rpt_dec;
        I_CE && alarm_hit && !wr && (s_r.con1[C1_CHIME] || s_r.con1[C1_RPT_LSB +: 8] != 8'h00)
        |=> s_r.con1[C1_RPT_LSB +: 8] == 8'($past(s_r.con1[C1_RPT_LSB +: 8]) - 8'h1);
    endproperty
    a_rpt_dec: assert property (p_rpt_dec) else $error("repeat not decremented");

    property p_rpt_hold;
        I_CE && alarm_hit && !wr && !s_r.con1[C1_CHIME] && s_r.con1[C1_RPT_LSB +: 8] == 8'h00
        |=> s_r.con1[C1_RPT_LSB +: 8] == 8'h00;
    endproperty
    a_rpt_hold: assert property (p_rpt_hold) else $error("repeat wrapped");

    property p_no_trim;
        I_CE && uf && s_r.con2[C2_FDIV_LSB +: 5] == 5'h00
        |=> s_r.cnt == $past(s_r.con2[C2_DIV_LSB +: 16]);
    endproperty
    a_no_trim: assert property (p_no_trim) else $error("trim applied at zero");

    property p_half_toggle;
        I_CE && uf |=> s_r.half != $past(s_r.half) && s_r.stat[0] == $past(s_r.half);
    endproperty
    a_half_toggle: assert property (p_half_toggle) else $error("half flag wrong");

    property p_off_still;
        I_CE && !s_r.con1[C1_ON] && !wr |=> $stable(s_r.tim) && $stable(s_r.cnt);
    endproperty
    a_off_still: assert property (p_off_still) else $error("counting while off");

    property p_evt_set;
        I_CE && alarm_hit |=> s_r.evt;
    endproperty
    a_evt_set: assert property (p_evt_set) else $error("alarm event not flagged");

    property p_evt_clear;
        I_CE && s_r.evt && uf && !alarm_hit |=> !s_r.evt;
    endproperty
    a_evt_clear: assert property (p_evt_clear) else $error("alarm event kept");

    property p_pin_on;
        I_CE && s_r.con1[C1_OE] |=> O_CC_PIN_OE;
    endproperty
    a_pin_on: assert property (p_pin_on) else $error("pin not driven while on");

    property p_first_half;
        I_CE && sec_adv |=> !s_r.half;
    endproperty
    a_first_half: assert property (p_first_half) else $error("half flag after second");

    property p_stat_zero;
        I_CE && req && !s_r.ack && ofs == OFS_STAT
        |=> O_AVS_READDATA[31:6] == 26'h0 && O_AVS_READDATA[4:3] == 2'h0;
    endproperty
    a_stat_zero: assert property (p_stat_zero) else $error("status spare bits set");

    property p_stat_copy;
        I_CE |=> s_r.stat[2] == $past(sync_f) && s_r.stat[1] == $past(async_f);
    endproperty
    a_stat_copy: assert property (p_stat_copy) else $error("status copy wrong");
endmodule
`default_nettype wire

// *** rtcs_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module rtcs_top_test;
    import rtcs_pkg::*;
    logic        clk;
    logic        rst_n;
    logic [7:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rdata;
    logic        wait_req;
    logic        unlocked;
    logic        ce;
    logic [2:0]  src;
    logic        o_pin;
    logic        o_pin_oe;
    logic        o_evt;
    logic        o_en;
    int          miscompares;
    int          comparisons;
    int          trims[3] = '{0, 1, 31};
    logic [31:0] alm_con[3] = '{32'h80018000, 32'h00000000, 32'hc0008000};
    logic [31:0] alm_exp[3] = '{32'h80008000, 32'h00008000, 32'hc0ff8000};

    rtcs_top u_rtcs_top (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_AVS_ADDRESS(addr),
        .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be),
        .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wait_req), .I_UNLOCKED(unlocked),
        .I_SECONDARY_CRYSTAL_OSC(src[0]), .I_LOW_POWER_RC_OSC(src[1]), .I_DEDICATED_CLOCK_PIN(src[2]), .O_CC_PIN(o_pin),
        .O_CC_PIN_OE(o_pin_oe), .O_ALARM_EVENT(o_evt), .O_ENABLED(o_en));

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic end_of_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Request held until waitrequest is sampled low, then released at once; one idle edge follows
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= ~w;
        @(posedge clk);
        while (wait_req !== 1'b0 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        q = rdata;
        if (n >= 50)
            chk("bus_wait", 32'h0, 32'h1);
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Cycles spanned by 16 periods of the pin (17 rising edges), i.e. 32 divider underflows
    task automatic span(output int c);
        int e;
        int t;
        logic p;
        e = -1;
        c = 0;
        t = 0;
        p = o_pin;
        while (e < 16 && t < 3000)
        begin
            @(posedge clk);
            t++;
            if (o_pin === 1'b1 && p === 1'b0)
                e++;
            if (e >= 0)
                c++;
            p = o_pin;
        end
    endtask

    task automatic poll_stat(output logic [31:0] o, output logic [31:0] a);
        logic [31:0] q;
        o = 32'h0;
        a = 32'hffffffff;
        repeat (40)
        begin
            bus(1'b0, OFS_STAT, 32'h0, q);
            o = o | q;
            a = a & q;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (30000) @(posedge clk);
        chk("watchdog", 32'h0, 32'h1);
        end_of_test();
    end

    initial
    begin
        logic [31:0] q;
        logic [31:0] so;
        logic [31:0] sa;
        int          c;
        int          n;
        int          seen;
        rst_n = 1'b0;
        addr = 8'h00;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h0;
        be = 4'hf;
        unlocked = 1'b0;
        ce = 1'b1;
        src = 3'h0;
        miscompares = 0;
        comparisons = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (alm_exp[i])
            rd_chk("reset_val", 8'(OFS_CON1 + 8'h10 * i), RESET_REG);
        rd_chk("reset_time", OFS_TIME, RESET_REG);
        // Register masks, lane enables and the atomic clear, set and invert views
        wr32(OFS_CON2, 32'hffffffff);
        rd_chk("con2_mask", OFS_CON2, CON2_MASK);
        wr32(8'(OFS_CON2 + 8'h4), 32'hffff0000);
        rd_chk("con2_clr", OFS_CON2, 32'h0000f803);
        wr32(8'(OFS_CON2 + 8'hc), 32'h00000003);
        rd_chk("con2_inv", OFS_CON2, 32'h0000f800);
        wr32(8'(OFS_CON2 + 8'h8), 32'h00050000);
        be <= 4'h1;
        wr32(OFS_CON2, 32'hffffffff);
        be <= 4'hf;
        rd_chk("con2_lane", OFS_CON2, 32'h0005f803);
        wr32(OFS_TIME, 32'ha3d958ff);
        rd_chk("time_bcd", OFS_TIME, 32'h23595800);
        wr32(OFS_ALM, 32'ha3d958ff);
        rd_chk("alarm_bcd", OFS_ALM, 32'h23595800);
        wr32(OFS_STAT, 32'hffffffff);
        rd_chk("stat_ro", OFS_STAT, 32'h0);
        wr32(8'h20, 32'hffffffff);
        rd_chk("unmapped", 8'h20, 32'h0);
        // Lock blocks timekeeping writes; clearing it needs the unlock level
        wr32(OFS_CON1, 32'hffff7fff);
        rd_chk("con1_mask", OFS_CON1, CON1_MASK & 32'hffff7fff);
        idle(2);
        chk("pin_oe_on", 32'h1, {31'h0, o_pin_oe});
        wr32(OFS_CON2, 32'h0);
        rd_chk("con2_locked", OFS_CON2, 32'h0005f803);
        wr32(OFS_TIME, 32'h0);
        rd_chk("time_locked", OFS_TIME, 32'h23595800);
        wr32(8'(OFS_CON1 + 8'h4), 32'h00000800);
        rd_chk("lock_kept", OFS_CON1, 32'hcfff08f0);
        unlocked <= 1'b1;
        wr32(8'(OFS_CON1 + 8'h4), 32'h00000800);
        unlocked <= 1'b0;
        rd_chk("lock_freed", OFS_CON1, 32'hcfff00f0);
        // Source select routed to the pin, selected input driven opposite to the other two
        wr32(OFS_CON1, 32'h00008080 | 32'(OSEL_SRCCLK) << C1_OSEL_LSB);
        for (int k = 0; k < 3; k++)
        begin
            wr32(OFS_CON2, 32'(k));
            src <= 3'(1 << k);
            idle(8);
            chk("pin_src_hi", 32'h1, {31'h0, o_pin});
            src <= 3'h7 ^ 3'(1 << k);
            idle(8);
            chk("pin_src_lo", 32'h0, {31'h0, o_pin});
        end
        wr32(OFS_CON1, 32'h00008000);
        idle(2);
        chk("pin_oe_off", 32'h0, {31'h0, o_pin_oe});
        // Seconds clock on the pin: 32 underflows of 5 ticks plus the trim
        // Short divide keeps the run brief; software aims at half a second
        wr32(OFS_CON1, 32'h00008080 | 32'(OSEL_SECONDS) << C1_OSEL_LSB);
        chk("enabled", 32'h1, {31'h0, o_en});
        foreach (trims[i])
        begin
            wr32(OFS_CON2, {16'h0004, trims[i][4:0], 9'h0, CSEL_PERIPH});
            idle(30);
            span(c);
            chk("trim_span", 32'(160 + trims[i]), 32'(c - 1));
        end
        // Clock enable low freezes the divider, so the seconds pin stands
        ce <= 1'b0;
        idle(2);
        q = {31'h0, o_pin};
        n = 0;
        repeat (30)
        begin
            @(posedge clk);
            if ({31'h0, o_pin} !== q)
                n++;
        end
        ce <= 1'b1;
        chk("ce_freeze", 32'h0, 32'(n));
        // Carry from 23:59:59 through to midnight
        wr32(OFS_TIME, 32'h23595800);
        seen = 0;
        for (int i = 0; i < 100 && seen < 2; i++)
        begin
            bus(1'b0, OFS_TIME, 32'h0, q);
            if (seen == 0 && q === 32'h23595900)
                seen = 1;
            if (seen == 1 && q === 32'h00000000)
                seen = 2;
        end
        chk("rollover", 32'h2, 32'(seen));
        poll_stat(so, sa);
        chk("stat_unused", 32'h0, so & 32'hffffffd8);
        chk("half_high", 32'h1, so & 32'h1);
        chk("half_low", 32'h0, sa & 32'h1);
        chk("sync_high", 32'h4, so & 32'h4);
        chk("sync_low", 32'h0, sa & 32'h4);
        chk("async_idle", 32'h0, so & 32'h2);
        // Disabled module must not count
        wr32(OFS_CON1, 32'h0);
        bus(1'b0, OFS_TIME, 32'h0, q);
        idle(60);
        rd_chk("time_frozen", OFS_TIME, q);
        chk("disabled", 32'h0, {31'h0, o_en});
        // Repeat count: decrement, stop at zero without chime, wrap with it
        wr32(OFS_ALM, 32'h00000200);
        foreach (alm_exp[i])
        begin
            if (alm_con[i] !== 32'h0)
                wr32(OFS_CON1, alm_con[i]);
            wr32(OFS_TIME, 32'h00000100);
            n = 0;
            while (o_evt !== 1'b1 && n < 200)
            begin
                @(posedge clk);
                n++;
            end
            chk("alarm_event", 32'h1, {31'h0, o_evt});
            @(posedge clk);
            chk("pin_alarm", 32'h1, {31'h0, o_pin});
            idle(2);
            rd_chk("alarm_count", OFS_CON1, alm_exp[i]);
        end
        poll_stat(so, sa);
        chk("async_high", 32'h2, so & 32'h2);
        end_of_test();
    end
endmodule
`default_nettype wire
